// *** pkg/hrpwm_pkg.sv ***
// Purpose: shared constants for the three-generator pwm block
// Assumes: 16-bit register port, word index addressing
// Notes: offsets are register indices
package hrpwm_pkg;
  localparam int unsigned HRPWM_NGEN = 3;
  localparam int unsigned HRPWM_W = 16;
  // register map, per generator block of 8 at base gen*8
  localparam logic [7:0] HRPWM_OFS_CTRL = 8'h00;
  localparam logic [7:0] HRPWM_OFS_PER = 8'h01;
  localparam logic [7:0] HRPWM_OFS_DUTY = 8'h02;
  localparam logic [7:0] HRPWM_OFS_PHASE = 8'h03;
  localparam logic [7:0] HRPWM_OFS_DEAD = 8'h04;
  localparam logic [7:0] HRPWM_OFS_TRIG1 = 8'h05;
  localparam logic [7:0] HRPWM_OFS_TRIG2 = 8'h06;
  localparam logic [7:0] HRPWM_GEN_STRIDE = 8'h08;
  localparam logic [7:0] HRPWM_OFS_GLOBAL = 8'h18;
  localparam logic [7:0] HRPWM_OFS_MPER0 = 8'h19;
  localparam logic [7:0] HRPWM_OFS_MPER1 = 8'h1A;
  localparam logic [7:0] HRPWM_OFS_ISTAT = 8'h1B;
  localparam logic [7:0] HRPWM_OFS_IMASK = 8'h1C;
  // control register fields
  localparam int unsigned HRPWM_B_IUE = 0;
  localparam int unsigned HRPWM_B_EXT_PERIOD_RST_SEL = 1;
  localparam int unsigned HRPWM_B_CAM = 2;
  localparam int unsigned HRPWM_B_MASTER_BASE_PICK = 3;
  localparam int unsigned HRPWM_B_DTC = 6;
  localparam int unsigned HRPWM_B_ITB = 9;
  localparam int unsigned HRPWM_B_SWAP = 10;
  localparam int unsigned HRPWM_B_PP = 11;
  localparam int unsigned HRPWM_B_CHOP = 12;
  localparam int unsigned HRPWM_B_CURRENT_LIMIT_MODE_SEL = 13;
  localparam int unsigned HRPWM_B_IND = 14;
  localparam logic [15:0] HRPWM_CTRL_RST = 16'h0000;
  localparam logic [15:0] HRPWM_CTRL_MASK = 16'h7ECF;
  // global register fields
  localparam int unsigned HRPWM_B_ON = 15;
  localparam int unsigned HRPWM_B_CHOPDIV = 0;
  localparam logic [15:0] HRPWM_PER_RST = 16'h0064;
  // dead-time codes
  localparam logic [1:0] HRPWM_DT_POS = 2'h0;
  localparam logic [1:0] HRPWM_DT_NEG = 2'h1;
  localparam logic [1:0] HRPWM_DT_OFF = 2'h2;
  // resolution: one fine tick per count, 3 lsbs dropped when centre aligned
  localparam int unsigned HRPWM_FINE_PS = 1040;
  localparam int unsigned HRPWM_COARSE_PS = 8320;
  localparam int unsigned HRPWM_CA_DROP = HRPWM_COARSE_PS / HRPWM_FINE_PS;
  localparam logic [15:0] HRPWM_CA_MASK = 16'hFFF8;
endpackage

// *** design/hrpwm_gen.sv ***
// Purpose: one pwm generator with its own time base and output pair
// Assumes: count enable is the global run bit; the chosen master base supplies only period and sync
// Notes: outputs registered; shadow registers load at period end, or every cycle while immediate update is set or the run bit is clear
`timescale 1ns/1ns
module hrpwm_gen #(
  parameter int unsigned W = 16
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // configuration
  input wire logic [15:0] ctrl_in,
  input wire logic [W-1:0] per_in,
  input wire logic [W-1:0] duty_in,
  input wire logic [W-1:0] phase_in,
  input wire logic [W-1:0] dead_in,
  input wire logic [W-1:0] trig1_in,
  input wire logic [W-1:0] trig2_in,
  input wire logic [W-1:0] mper_in,
  input wire logic tick_in,
  input wire logic sync_in,
  input wire logic run_in,
  input wire logic chop_in,
  input wire logic climit_in,
  input wire logic fault_in,
  // results
  output logic high_side_out,
  output logic low_side_out,
  output logic trig1_out,
  output logic trig2_out,
  output logic pend_out,
  output logic [W-1:0] cnt_out
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic dir;
    logic pp_sel;
    logic [W-1:0] a_per;
    logic [W-1:0] a_duty;
    logic [W-1:0] a_phase;
    logic [W-1:0] a_dead;
    logic hi;
    logic lo;
    logic t1;
    logic t2;
    logic pend;
  } hrpwm_gen_st_t;
  hrpwm_gen_st_t st_r;
  hrpwm_gen_st_t st_nxt;

  function automatic logic [W-1:0] ca_trim(input logic [W-1:0] v, input logic ca);
    ca_trim = ca ? (v & W'(hrpwm_pkg::HRPWM_CA_MASK)) : v;
  endfunction

  logic independent_base_sel;
  logic ca;
  logic [1:0] dead_time_ctl;
  logic [W-1:0] per;
  logic wrap;
  logic xrst;
  logic raw;
  logic a_on;
  logic b_on;
  logic [W-1:0] d;
  logic [W-1:0] t;
  // next-state logic
  always_comb
  begin
    st_nxt = st_r;
    independent_base_sel = ctrl_in[hrpwm_pkg::HRPWM_B_ITB];
    ca = independent_base_sel & ctrl_in[hrpwm_pkg::HRPWM_B_CAM];
    dead_time_ctl = ctrl_in[hrpwm_pkg::HRPWM_B_DTC +: 2];
    per = independent_base_sel ? st_r.a_per : mper_in;
    xrst = independent_base_sel & ctrl_in[hrpwm_pkg::HRPWM_B_EXT_PERIOD_RST_SEL] & ~ctrl_in[hrpwm_pkg::HRPWM_B_CURRENT_LIMIT_MODE_SEL] & climit_in;
    wrap = ca ? (st_r.dir & st_r.cnt == '0) : (st_r.cnt >= per);
    d = ca_trim(st_r.a_duty, ca);
    t = ca_trim(st_r.a_dead, ca);
    st_nxt.t1 = 1'b0;
    st_nxt.t2 = 1'b0;
    st_nxt.pend = 1'b0;
    // immediate or period-synchronous update
    if (ctrl_in[hrpwm_pkg::HRPWM_B_IUE] | (tick_in & wrap) | ~run_in)
    begin
      st_nxt.a_per = per_in;
      st_nxt.a_duty = duty_in;
      st_nxt.a_phase = phase_in;
      st_nxt.a_dead = dead_in;
    end
    if (~run_in | xrst)
    begin
      st_nxt.cnt = '0;
      st_nxt.dir = 1'b0;
    end
    // master sync is registered a cycle late, so step one past the phase to stay level with it
    else if (~independent_base_sel & sync_in)
      st_nxt.cnt = ca_trim(st_r.a_phase, ca) + W'(1);
    else if (tick_in)
    begin
      if (wrap)
      begin
        st_nxt.cnt = independent_base_sel ? ca_trim(st_r.a_phase, ca) : '0;
        st_nxt.dir = 1'b0;
        st_nxt.pp_sel = ~st_r.pp_sel;
        st_nxt.pend = 1'b1;
      end
      else if (ca & (st_r.dir | st_r.cnt >= per))
      begin
        st_nxt.dir = 1'b1;
        st_nxt.cnt = st_r.cnt - W'(1);
      end
      else
        st_nxt.cnt = st_r.cnt + W'(1);
      st_nxt.t1 = st_r.cnt == trig1_in;
      st_nxt.t2 = st_r.cnt == trig2_in;
    end
    raw = ca ? (st_r.cnt < (d >> 1)) : (st_r.cnt < d);
    // dead time: high waits t after raw rises, low waits t after raw falls
    a_on = raw & (st_r.cnt >= t);
    b_on = ~raw & ((st_r.cnt >= d + t) | ~(dead_time_ctl == hrpwm_pkg::HRPWM_DT_POS));
    if (dead_time_ctl == hrpwm_pkg::HRPWM_DT_OFF | dead_time_ctl == 2'h3)
    begin
      a_on = raw;
      b_on = ~raw;
    end
    else if (dead_time_ctl == hrpwm_pkg::HRPWM_DT_NEG & ~ctrl_in[hrpwm_pkg::HRPWM_B_IND])
    begin
      a_on = raw | (st_r.cnt < d + t); // overlap only in complementary mode
      b_on = ~raw;
    end
    if (ctrl_in[hrpwm_pkg::HRPWM_B_PP])
    begin
      a_on = raw & ~st_r.pp_sel;
      b_on = raw & st_r.pp_sel;
    end
    else if (ctrl_in[hrpwm_pkg::HRPWM_B_IND])
      b_on = raw;
    if (ctrl_in[hrpwm_pkg::HRPWM_B_CHOP])
    begin
      a_on = a_on & chop_in;
      b_on = b_on & chop_in;
    end
    // fault forces both off; swap after all shaping
    st_nxt.hi = run_in & ~fault_in & (ctrl_in[hrpwm_pkg::HRPWM_B_SWAP] ? b_on : a_on);
    st_nxt.lo = run_in & ~fault_in & (ctrl_in[hrpwm_pkg::HRPWM_B_SWAP] ? a_on : b_on);
  end

  // state register
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign high_side_out = st_r.hi;
  assign low_side_out = st_r.lo;
  assign trig1_out = st_r.t1;
  assign trig2_out = st_r.t2;
  assign pend_out = st_r.pend;
  assign cnt_out = st_r.cnt;

  AST_FAULT_OFF: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    fault_in |=> !high_side_out && !low_side_out) else $error("fault did not clear outputs");
  AST_NO_OVERLAP: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (ctrl_in[hrpwm_pkg::HRPWM_B_DTC +: 2] == 2'h0 && ctrl_in[hrpwm_pkg::HRPWM_B_IND +: 1] == 1'b0
     && $stable(ctrl_in)) |=> !(high_side_out && low_side_out)) else $error("outputs overlap");
  AST_IUE_LOAD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    ctrl_in[hrpwm_pkg::HRPWM_B_IUE] |=> st_r.a_duty == $past(duty_in)) else $error("immediate update missed");
  AST_CA_DUTY: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    ca |-> d[2:0] == 3'h0) else $error("centre duty lsbs not dropped");
  AST_PP_ALT: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (tick_in && wrap && run_in && !xrst && (independent_base_sel || !sync_in)) |=> st_r.pp_sel != $past(st_r.pp_sel))
    else $error("push-pull did not alternate");
endmodule

// *** design/hrpwm_top.sv ***
// Purpose: three pwm generators, two master bases, register port, interrupt
// Assumes: one 25 MHz clock; one count per enabled clock; pins are async
// Notes: register index addressing, read data one cycle after read strobe
`timescale 1ns/1ns
module hrpwm_top #(
  parameter int unsigned NGEN = hrpwm_pkg::HRPWM_NGEN,
  parameter int unsigned W = hrpwm_pkg::HRPWM_W
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  // protection pins, one per generator
  input wire logic [NGEN-1:0] fault_pin_in,
  input wire logic [NGEN-1:0] climit_pin_in,
  // outputs
  output logic [NGEN-1:0] high_side_out,
  output logic [NGEN-1:0] low_side_out,
  output logic [NGEN-1:0] adc_trig1_out,
  output logic [NGEN-1:0] adc_trig2_out,
  output logic irq_out
);
  typedef struct packed {
    logic [NGEN-1:0][15:0] ctrl;
    logic [NGEN-1:0][W-1:0] per;
    logic [NGEN-1:0][W-1:0] duty;
    logic [NGEN-1:0][W-1:0] phase;
    logic [NGEN-1:0][W-1:0] dead;
    logic [NGEN-1:0][W-1:0] trig1;
    logic [NGEN-1:0][W-1:0] trig2;
    logic [15:0] glob;
    logic [1:0][W-1:0] mper;
    logic [1:0][W-1:0] mcnt;
    logic [1:0] msync;
    logic [7:0] chop_cnt;
    logic chop;
    logic [NGEN-1:0] istat;
    logic [NGEN-1:0] imask;
    logic [15:0] rdata;
    logic irq;
    logic [NGEN-1:0] hi;
    logic [NGEN-1:0] lo;
    logic [NGEN-1:0] t1;
    logic [NGEN-1:0] t2;
  } hrpwm_st_t;
  hrpwm_st_t st_r;
  hrpwm_st_t st_nxt;

  // pin synchronisers; first stage read only by the second
  logic [NGEN-1:0] flt_s1_r;
  logic [NGEN-1:0] flt_s2_r;
  logic [NGEN-1:0] cl_s1_r;
  logic [NGEN-1:0] cl_s2_r;
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      flt_s1_r <= '0;
      flt_s2_r <= '0;
      cl_s1_r <= '0;
      cl_s2_r <= '0;
    end
    else
    begin
      flt_s1_r <= fault_pin_in;
      flt_s2_r <= flt_s1_r;
      cl_s1_r <= climit_pin_in;
      cl_s2_r <= cl_s1_r;
    end
  end

  // generator results
  logic [NGEN-1:0] g_hi;
  logic [NGEN-1:0] g_lo;
  logic [NGEN-1:0] g_t1;
  logic [NGEN-1:0] g_t2;
  logic [NGEN-1:0] g_pend;
  logic run;
  assign run = st_r.glob[hrpwm_pkg::HRPWM_B_ON];

  // generator instances, each with its own pins
  for (genvar g = 0; g < NGEN; g++)
  begin : gen_g
    logic sel;
    assign sel = st_r.ctrl[g][hrpwm_pkg::HRPWM_B_MASTER_BASE_PICK];
    hrpwm_gen #(.W(W)) u_gen (
      .mclk_in(mclk_in),
      .rst_b_in(rst_b_in),
      .ctrl_in(st_r.ctrl[g]),
      .per_in(st_r.per[g]),
      .duty_in(st_r.duty[g]),
      .phase_in(st_r.phase[g]),
      .dead_in(st_r.dead[g]),
      .trig1_in(st_r.trig1[g]),
      .trig2_in(st_r.trig2[g]),
      .mper_in(st_r.mper[sel]),
      .tick_in(run),
      .sync_in(st_r.msync[sel]),
      .run_in(run),
      .chop_in(st_r.chop),
      .climit_in(cl_s2_r[g]),
      .fault_in(flt_s2_r[g]),
      .high_side_out(g_hi[g]),
      .low_side_out(g_lo[g]),
      .trig1_out(g_t1[g]),
      .trig2_out(g_t2[g]),
      .pend_out(g_pend[g]),
      .cnt_out()
    );
  end

  function automatic logic [7:0] gen_base(input int unsigned g);
    gen_base = 8'(g) * hrpwm_pkg::HRPWM_GEN_STRIDE;
  endfunction

  // registers, master bases, chop divider, interrupt
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.hi = g_hi;
    st_nxt.lo = g_lo;
    st_nxt.t1 = g_t1;
    st_nxt.t2 = g_t2;
    st_nxt.rdata = 16'h0000;
    // two shared master time bases, sync pulse at wrap
    for (int m = 0; m < 2; m++)
    begin
      st_nxt.msync[m] = 1'b0;
      if (!run)
        st_nxt.mcnt[m] = '0;
      else if (st_r.mcnt[m] >= st_r.mper[m])
      begin
        st_nxt.mcnt[m] = '0;
        st_nxt.msync[m] = 1'b1;
      end
      else
        st_nxt.mcnt[m] = st_r.mcnt[m] + W'(1);
    end
    // chop clock, half period set by low byte of the global register
    if (st_r.chop_cnt >= st_r.glob[7:0])
    begin
      st_nxt.chop_cnt = 8'h00;
      st_nxt.chop = ~st_r.chop;
    end
    else
      st_nxt.chop_cnt = st_r.chop_cnt + 8'h01;
    // register writes
    if (reg_wr_in)
    begin
      for (int g = 0; g < NGEN; g++)
      begin
        if (reg_addr_in == gen_base(g) + hrpwm_pkg::HRPWM_OFS_CTRL)
          st_nxt.ctrl[g] = reg_wdata_in & hrpwm_pkg::HRPWM_CTRL_MASK;
        if (reg_addr_in == gen_base(g) + hrpwm_pkg::HRPWM_OFS_PER)
          st_nxt.per[g] = reg_wdata_in[W-1:0];
        if (reg_addr_in == gen_base(g) + hrpwm_pkg::HRPWM_OFS_DUTY)
          st_nxt.duty[g] = reg_wdata_in[W-1:0];
        if (reg_addr_in == gen_base(g) + hrpwm_pkg::HRPWM_OFS_PHASE)
          st_nxt.phase[g] = reg_wdata_in[W-1:0];
        if (reg_addr_in == gen_base(g) + hrpwm_pkg::HRPWM_OFS_DEAD)
          st_nxt.dead[g] = reg_wdata_in[W-1:0];
        if (reg_addr_in == gen_base(g) + hrpwm_pkg::HRPWM_OFS_TRIG1)
          st_nxt.trig1[g] = reg_wdata_in[W-1:0];
        if (reg_addr_in == gen_base(g) + hrpwm_pkg::HRPWM_OFS_TRIG2)
          st_nxt.trig2[g] = reg_wdata_in[W-1:0];
      end
      if (reg_addr_in == hrpwm_pkg::HRPWM_OFS_GLOBAL)
        st_nxt.glob = reg_wdata_in;
      if (reg_addr_in == hrpwm_pkg::HRPWM_OFS_MPER0)
        st_nxt.mper[0] = reg_wdata_in[W-1:0];
      if (reg_addr_in == hrpwm_pkg::HRPWM_OFS_MPER1)
        st_nxt.mper[1] = reg_wdata_in[W-1:0];
      if (reg_addr_in == hrpwm_pkg::HRPWM_OFS_IMASK)
        st_nxt.imask = reg_wdata_in[NGEN-1:0];
      if (reg_addr_in == hrpwm_pkg::HRPWM_OFS_ISTAT)
        st_nxt.istat = st_r.istat & ~reg_wdata_in[NGEN-1:0];
    end
    // new period events win over a same-cycle clear
    st_nxt.istat = st_nxt.istat | g_pend;
    // register reads, unmapped reads return zero
    if (reg_rd_in)
    begin
      for (int g = 0; g < NGEN; g++)
      begin
        if (reg_addr_in == gen_base(g) + hrpwm_pkg::HRPWM_OFS_CTRL)
          st_nxt.rdata = st_r.ctrl[g] | {st_r.istat[g], 15'h0000};
        if (reg_addr_in == gen_base(g) + hrpwm_pkg::HRPWM_OFS_PER)
          st_nxt.rdata = 16'(st_r.per[g]);
        if (reg_addr_in == gen_base(g) + hrpwm_pkg::HRPWM_OFS_DUTY)
          st_nxt.rdata = 16'(st_r.duty[g]);
        if (reg_addr_in == gen_base(g) + hrpwm_pkg::HRPWM_OFS_PHASE)
          st_nxt.rdata = 16'(st_r.phase[g]);
        if (reg_addr_in == gen_base(g) + hrpwm_pkg::HRPWM_OFS_DEAD)
          st_nxt.rdata = 16'(st_r.dead[g]);
        if (reg_addr_in == gen_base(g) + hrpwm_pkg::HRPWM_OFS_TRIG1)
          st_nxt.rdata = 16'(st_r.trig1[g]);
        if (reg_addr_in == gen_base(g) + hrpwm_pkg::HRPWM_OFS_TRIG2)
          st_nxt.rdata = 16'(st_r.trig2[g]);
      end
      if (reg_addr_in == hrpwm_pkg::HRPWM_OFS_GLOBAL)
        st_nxt.rdata = st_r.glob;
      if (reg_addr_in == hrpwm_pkg::HRPWM_OFS_MPER0)
        st_nxt.rdata = 16'(st_r.mper[0]);
      if (reg_addr_in == hrpwm_pkg::HRPWM_OFS_MPER1)
        st_nxt.rdata = 16'(st_r.mper[1]);
      if (reg_addr_in == hrpwm_pkg::HRPWM_OFS_ISTAT)
        st_nxt.rdata = 16'(st_r.istat);
      if (reg_addr_in == hrpwm_pkg::HRPWM_OFS_IMASK)
        st_nxt.rdata = 16'(st_r.imask);
    end
    st_nxt.irq = |(st_nxt.istat & st_nxt.imask);
  end

  // state register
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      st_r <= '0;
      st_r.per <= {NGEN{W'(hrpwm_pkg::HRPWM_PER_RST)}};
      st_r.mper <= {2{W'(hrpwm_pkg::HRPWM_PER_RST)}};
    end
    else
      st_r <= st_nxt;
  end

  assign reg_rdata_out = st_r.rdata;
  assign high_side_out = st_r.hi;
  assign low_side_out = st_r.lo;
  assign adc_trig1_out = st_r.t1;
  assign adc_trig2_out = st_r.t2;
  assign irq_out = st_r.irq;

  AST_IRQ_LEVEL: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    irq_out == |(st_r.istat & st_r.imask)) else $error("irq not tied to status");
  AST_MSYNC_PER: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (run && st_r.mcnt[0] == st_r.mper[0]) |=> st_r.msync[0] && st_r.mcnt[0] == '0)
    else $error("master base wrap wrong");
  AST_STAT_SET_WINS: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    g_pend[0] |=> st_r.istat[0]) else $error("status event lost");
endmodule

// *** test/hrpwm_sw_model.sv ***
// Purpose: power switch pairs as seen from the gate pins
// Assumes: one gate pair and two converter triggers per generator
// Notes: statistics only gather while enabled, so a stopped block adds nothing
`timescale 1ns/1ns
module hrpwm_sw_model #(
  parameter int unsigned NGEN = 3
) (
  // clock and controls
  input wire logic mclk_in,
  input wire logic clr_in,
  input wire logic en_in,
  // gate pins and triggers
  input wire logic [NGEN-1:0] high_side_in,
  input wire logic [NGEN-1:0] low_side_in,
  input wire logic [NGEN-1:0] trig1_in,
  input wire logic [NGEN-1:0] trig2_in,
  // statistics
  output logic [NGEN-1:0][15:0] hi_cnt_out,
  output logic [NGEN-1:0][15:0] lo_cnt_out,
  output logic [NGEN-1:0][7:0] t1_cnt_out,
  output logic [NGEN-1:0][7:0] t2_cnt_out,
  output logic [NGEN-1:0] short_out
);
  // both legs of one pair on at once would short the supply rail
  always_ff @(posedge mclk_in)
  begin
    if (clr_in)
    begin
      hi_cnt_out <= '0;
      lo_cnt_out <= '0;
      t1_cnt_out <= '0;
      t2_cnt_out <= '0;
      short_out <= '0;
    end
    else if (en_in)
    begin
      for (int g = 0; g < NGEN; g++)
      begin
        hi_cnt_out[g] <= hi_cnt_out[g] + 16'(high_side_in[g]);
        lo_cnt_out[g] <= lo_cnt_out[g] + 16'(low_side_in[g]);
        t1_cnt_out[g] <= t1_cnt_out[g] + 8'(trig1_in[g]);
        t2_cnt_out[g] <= t2_cnt_out[g] + 8'(trig2_in[g]);
        short_out[g] <= short_out[g] | (high_side_in[g] & low_side_in[g]);
      end
    end
  end
endmodule

// *** test/tb.sv ***
// Purpose: self-checking bench for the three-generator pwm block
// Assumes: pin behaviour judged from counts over windows of many periods
// Notes: reads and pin probes are checked from two queues by one watcher
`timescale 1ns/1ns
`define CMP(got, exp, what) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp); \
    end \
  end
module tb;
  localparam int unsigned NGEN = hrpwm_pkg::HRPWM_NGEN;
  localparam logic [7:0] GLB = hrpwm_pkg::HRPWM_OFS_GLOBAL;
  localparam logic [7:0] IST = hrpwm_pkg::HRPWM_OFS_ISTAT;
  // design ports
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [15:0] reg_rdata_out;
  logic [NGEN-1:0] fault_pin_in = '0;
  logic [NGEN-1:0] climit_pin_in = '0;
  logic [NGEN-1:0] high_side_out, low_side_out, adc_trig1_out, adc_trig2_out;
  logic irq_out;
  // bench state
  logic clr = 1'b1;
  logic en = 1'b0;
  logic cl_on = 1'b0;
  logic [NGEN-1:0][15:0] hi_cnt, lo_cnt;
  logic [NGEN-1:0][7:0] t1_cnt, t2_cnt;
  logic [NGEN-1:0] shorted;
  logic chk_v = 1'b0;
  logic chk_val = 1'b0;
  logic rd_d = 1'b0;
  logic [15:0] rd_q[$];
  logic chk_q[$];
  logic [15:0] e_rd, v;
  logic e_ck;
  int error_cnt = 0;
  int n_compared = 0;
  int seed;

  always #20 mclk_in = ~mclk_in;

  hrpwm_top i_dut (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .fault_pin_in(fault_pin_in), .climit_pin_in(climit_pin_in), .high_side_out(high_side_out),
    .low_side_out(low_side_out), .adc_trig1_out(adc_trig1_out), .adc_trig2_out(adc_trig2_out),
    .irq_out(irq_out)
  );

  hrpwm_sw_model i_sw (
    .mclk_in(mclk_in), .clr_in(clr), .en_in(en), .high_side_in(high_side_out), .low_side_in(low_side_out),
    .trig1_in(adc_trig1_out), .trig2_in(adc_trig2_out), .hi_cnt_out(hi_cnt), .lo_cnt_out(lo_cnt),
    .t1_cnt_out(t1_cnt), .t2_cnt_out(t2_cnt), .short_out(shorted)
  );

  // toggling every cycle gives the limit pin both an edge and a level
  always @(posedge mclk_in)
    climit_pin_in <= cl_on ? ~climit_pin_in & 3'b101 : 3'b000;

  // read data stand one cycle after the strobe; probes compare at once
  always @(posedge mclk_in)
  begin
    rd_d <= reg_rd_in;
    if (rd_d)
    begin
      e_rd = rd_q.pop_front();
      `CMP(reg_rdata_out, e_rd, "read")
    end
    if (chk_v)
    begin
      e_ck = chk_q.pop_front();
      `CMP(chk_val, e_ck, "probe")
    end
  end

  function automatic logic [7:0] ga(input int g, input logic [7:0] o);
    return 8'(g) * hrpwm_pkg::HRPWM_GEN_STRIDE + o;
  endfunction

  // every call sets all strobes, so none is assigned twice in one step
  task automatic drive(input logic w, input logic r, input logic c, input logic [7:0] a, input logic [15:0] d);
  begin
    reg_wr_in <= w;
    reg_rd_in <= r;
    chk_v <= c;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
  end
  endtask

  task automatic idle(input int n);
    repeat (n) drive(1'b0, 1'b0, 1'b0, 8'h00, 16'h0000);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    drive(1'b1, 1'b0, 1'b0, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
  begin
    rd_q.push_back(e);
    drive(1'b0, 1'b1, 1'b0, a, 16'h0000);
  end
  endtask

  task automatic chk(input logic ok);
  begin
    chk_q.push_back(1'b1);
    chk_val <= ok;
    drive(1'b0, 1'b0, 1'b1, 8'h00, 16'h0000);
  end
  endtask

  // configuration is only touched while the generators stand still
  task automatic run(input logic [15:0] glb, input int n);
  begin
    clr <= 1'b1;
    idle(1);
    clr <= 1'b0;
    en <= 1'b1;
    wr(GLB, 16'h8000 | glb);
    idle(n);
    en <= 1'b0;
    wr(GLB, 16'h0000);
    idle(2);
  end
  endtask

  task automatic summarize;
  begin
    if (error_cnt == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask

  // a hang costs at most a few times the expected run
  initial
  begin
    repeat (5000) @(posedge mclk_in);
    error_cnt++;
    $display("[FAIL] %0t timeout", $time);
    summarize();
  end

  initial
  begin
    seed = $urandom(32'h6265a975);
    repeat (2) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    // reset values, the spare slot of each block and a far address
    for (int g = 0; g < NGEN; g++)
    begin
      rd(ga(g, 8'h00), hrpwm_pkg::HRPWM_CTRL_RST);
      rd(ga(g, 8'h01), hrpwm_pkg::HRPWM_PER_RST);
      for (int o = 2; o < 8; o++)
        rd(ga(g, 8'(o)), 16'h0000);
    end
    for (int o = 0; o < 5; o++)
      rd(GLB + 8'(o), (o == 1 || o == 2) ? hrpwm_pkg::HRPWM_PER_RST : 16'h0000);
    rd(8'hFF, 16'h0000);
    // each dead-time code beside random bits; unused bits read zero
    for (int g = 0; g < NGEN; g++)
      for (int c = 0; c < 4; c++)
      begin
        v = 16'($urandom()) & 16'hFF3F | 16'(c << 6);
        wr(ga(g, 8'h00), v);
        rd(ga(g, 8'h00), v & hrpwm_pkg::HRPWM_CTRL_MASK);
      end
    for (int g = 0; g < NGEN; g++)
      for (int o = 1; o < 7; o++)
      begin
        v = 16'($urandom());
        wr(ga(g, 8'(o)), v);
        rd(ga(g, 8'(o)), v);
      end
    // short primary base, long secondary: only some generators wrap
    wr(GLB + 8'h01, 16'h0010);
    wr(GLB + 8'h02, 16'hF000);
    for (int g = 0; g < NGEN; g++)
    begin
      wr(ga(g, 8'h01), 16'h0010);
      wr(ga(g, 8'h02), 16'h0004);
      wr(ga(g, 8'h03), 16'h0000);
      wr(ga(g, 8'h04), 16'h0002);
      wr(ga(g, 8'h05), 16'h0002);
      wr(ga(g, 8'h06), 16'h0009);
    end
    wr(ga(0, 8'h00), 16'h0080);
    wr(ga(1, 8'h00), 16'h0088);
    wr(ga(2, 8'h00), 16'h0280);
    wr(IST + 8'h01, 16'h0001);
    run(16'h0000, 200);
    rd(IST, 16'h0005);
    rd(ga(0, 8'h00), 16'h8080);
    chk(irq_out);
    chk(hi_cnt[0] < lo_cnt[0]);
    chk(t1_cnt[0] != 0 && t2_cnt[0] != 0);
    // a masked pending bit must not hold the line once the other clears
    wr(IST, 16'h0001);
    idle(3);
    rd(IST, 16'h0004);
    chk(!irq_out);
    // limit pulses keep restarting gen 2; gen 0 ignores its own
    wr(ga(2, 8'h00), 16'h0282);
    wr(IST, 16'h0004);
    cl_on <= 1'b1;
    run(16'h0000, 200);
    cl_on <= 1'b0;
    rd(IST, 16'h0001);
    // gen 0 swapped, gen 1 faulted, gen 2 push-pull, its positive dead-time code overridden
    fault_pin_in <= 3'b010;
    wr(ga(0, 8'h00), 16'h0480);
    wr(ga(1, 8'h00), 16'h0080);
    wr(ga(2, 8'h00), 16'h0A00);
    run(16'h0000, 200);
    fault_pin_in <= 3'b000;
    chk(hi_cnt[0] > lo_cnt[0]);
    chk(hi_cnt[1] == 0 && lo_cnt[1] == 0);
    chk(hi_cnt[2] != 0 && lo_cnt[2] != 0 && !shorted[2]);
    // same duty: gen 0 gated, gen 1 complementary with dead time
    wr(ga(0, 8'h02), 16'h0008);
    wr(ga(1, 8'h02), 16'h0008);
    wr(ga(0, 8'h00), 16'h1080);
    wr(ga(1, 8'h00), 16'h0000);
    run(16'h0002, 200);
    chk(hi_cnt[0] < hi_cnt[1]);
    chk(hi_cnt[1] != 0 && !shorted[1]);
    // gen 0 centre bit without own base plus negative dead time; gens 1 and 2 centred, duty low bits differ
    wr(ga(0, 8'h00), 16'h0044);
    wr(ga(1, 8'h00), 16'h0284);
    wr(ga(2, 8'h00), 16'h0284);
    wr(ga(1, 8'h02), 16'h000F);
    wr(ga(2, 8'h02), 16'h0008);
    run(16'h0000, 200);
    chk(hi_cnt[0] > hi_cnt[1]);
    chk(shorted[0]);
    chk(hi_cnt[1] == hi_cnt[2] && hi_cnt[1] != 0);
    summarize();
  end
endmodule
